/* File: shared/arm_defs.svh */
// Constants of the task-file read command interpreter and its controller.
`ifndef ARM_DEFS_SVH
`define ARM_DEFS_SVH
// ----------------------------------------
// Task-file addresses on the link
// ----------------------------------------
`define ARM_TF_DATA 4'h0
`define ARM_TF_ERR 4'h1
`define ARM_TF_CNT 4'h2
`define ARM_TF_SEC 4'h3
`define ARM_TF_CYL_LO 4'h4
`define ARM_TF_CYL_HI 4'h5
`define ARM_TF_DEV_HEAD 4'h6
`define ARM_TF_CMD 4'h7
`define ARM_TF_DEV_CTL 4'h8
// ----------------------------------------
// Opcodes, fields and limits
// ----------------------------------------
`define ARM_OP_NATIVE_MAX 8'hf8
`define ARM_OP_NATIVE_MAX_EXT 8'h27
`define ARM_OP_READ_SECTORS 8'h20
`define ARM_SAT_28 28'hfffffff
`define ARM_BIT_LBA 6
`define ARM_BIT_HOB 7
`define ARM_DEV_HEAD_BASE 8'ha0
`define ARM_ST_BSY 7
`define ARM_ST_DRQ 3
`define ARM_ST_ERR 0
`define ARM_ST_IDLE 8'h50
`define ARM_ER_UNC 6
`define ARM_ER_ABT 2
// ----------------------------------------
// Controller register offsets (AXI4-Lite)
// ----------------------------------------
`define ARM_AX_CTRL 8'h00
`define ARM_AX_ADDR 8'h04
`define ARM_AX_COUNT 8'h08
`define ARM_AX_STATUS 8'h0c
`define ARM_AX_RES_LO 8'h10
`define ARM_AX_RES_HI 8'h14
`define ARM_AX_DATA 8'h18
`define ARM_RESP_OKAY 2'b00
`define ARM_RESP_SLVERR 2'b10
`endif

/* File: shared/arm_pkg.sv */
// Types for the two ends of the task-file link: each end's state encoding and the controller's link operation.
package arm_pkg;
  typedef enum logic [2:0] {
    DEV_IDLE = 3'b001,
    DEV_FETCH = 3'b010,
    DEV_DRAIN = 3'b100
  } arm_dev_state_t;

  typedef enum logic [3:0] {
    HOST_IDLE = 4'b0001,
    HOST_ISSUE = 4'b0010,
    HOST_WAIT = 4'b0100,
    HOST_HOLD = 4'b1000
  } arm_host_state_t;

  typedef struct packed {
    logic wr;
    logic [3:0] addr;
    logic [7:0] data;
  } arm_op_t;
endpackage : arm_pkg

/* File: shared/arm_if.sv */
// Task-file link between the controller and the drive command logic.
`timescale 1ns/100ps
interface arm_if;
  logic tf_wr;
  logic tf_rd;
  logic [3:0] tf_addr;
  logic [7:0] tf_wdata;
  logic [15:0] tf_rdata;
  logic tf_ack;

  modport device (
    input tf_wr, tf_rd, tf_addr, tf_wdata,
    output tf_rdata, tf_ack
  );
  modport host (
    output tf_wr, tf_rd, tf_addr, tf_wdata,
    input tf_rdata, tf_ack
  );
endinterface : arm_if

/* File: core/arm_device.sv */
// Drive-side command logic with its sector word FIFO.
`timescale 1ns/100ps
`include "arm_defs.svh"

// ----------------------------------------
// Word FIFO
// ----------------------------------------
module arm_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Fill side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // Drain side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin
      $error("arm_fifo: DEPTH must be a power of two of at least 2");
    end
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic rdy;
  } arm_fifo_st_t;

  arm_fifo_st_t s_r, s_nxt;
  logic push, pop;

  always_comb begin
    s_nxt = s_r;
    push = in_valid && s_r.rdy;
    pop = out_ready && (s_r.cnt != '0);
    if (push) begin
      s_nxt.mem[s_r.wp] = in_data;
      s_nxt.wp = s_r.wp + 1'b1;
    end
    if (pop) begin
      s_nxt.rp = s_r.rp + 1'b1;
    end
    s_nxt.cnt = s_r.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    // Ready is registered so that the media side never sees a path through this block.
    s_nxt.rdy = s_nxt.cnt < (AW + 1)'(DEPTH);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign in_ready = s_r.rdy;
  assign out_valid = s_r.cnt != '0;
  assign out_data = s_r.mem[s_r.rp];
endmodule : arm_fifo

// ----------------------------------------
// Drive command logic
// ----------------------------------------
module arm_device #(
  parameter int SECTOR_WORDS = 256,
  parameter int FIFO_DEPTH = 8
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Task-file link
  arm_if.device tf,
  // Drive geometry and capacity
  input wire logic [47:0] native_max,
  input wire logic [15:0] max_cyl,
  input wire logic [3:0] max_head,
  input wire logic [7:0] max_sec,
  // Media word stream
  output logic media_req,
  output logic media_chs,
  output logic [27:0] media_addr,
  input wire logic media_valid,
  input wire logic [15:0] media_data,
  output logic media_ready,
  input wire logic media_err
);
  initial begin
    if (SECTOR_WORDS < 2 || SECTOR_WORDS > 256) begin
      $error("arm_device: SECTOR_WORDS must lie in 2..256");
    end
  end

  typedef struct packed {
    arm_pkg::arm_dev_state_t st;
    logic [7:0] cnt, sec, cl, ch;
    logic [7:0] p_cnt, p_sec, p_cl, p_ch;
    logic [7:0] dh;
    logic hob;
    logic [7:0] err;
    logic errb;
    logic [8:0] left;
    logic [7:0] wcnt;
    logic req;
    logic chs;
    logic [27:0] maddr;
    logic [15:0] rdata;
    logic ack;
  } arm_dev_st_t;

  arm_dev_st_t s_r, s_nxt;
  logic f_valid, f_pop;
  logic [15:0] f_data;
  logic [27:0] nm28;

  arm_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) u_fifo (
    .aclk(aclk),
    .aresetn(aresetn),
    .in_valid(media_valid && s_r.req),
    .in_data(media_data),
    .in_ready(media_ready),
    .out_valid(f_valid),
    .out_data(f_data),
    .out_ready(f_pop)
  );

  // Step to the next sector in whichever addressing form the command used.
  function automatic logic [31:0] next_addr(input logic chs, input logic [31:0] a,
                                            input logic [15:0] mc, input logic [3:0] mh,
                                            input logic [7:0] ms);
    logic [31:0] n;
    n = a;
    if (!chs) begin
      n[27:0] = a[27:0] + 28'h1;
    end else if (a[7:0] != ms) begin
      n[7:0] = a[7:0] + 8'h1;
    end else begin
      n[7:0] = 8'h01;
      if (a[27:24] != mh) begin
        n[27:24] = a[27:24] + 4'h1;
      end else begin
        n[27:24] = 4'h0;
        n[23:8] = (a[23:8] == mc) ? 16'h0 : a[23:8] + 16'h1;
      end
    end
    return n;
  endfunction : next_addr

  assign f_pop = tf.tf_rd && (tf.tf_addr == `ARM_TF_DATA) && f_valid;
  // Native max comes straight from the drive, never from any set-max limit.
  assign nm28 = (native_max > {20'h0, `ARM_SAT_28}) ? `ARM_SAT_28 : native_max[27:0];

  always_comb begin
    logic busy;
    logic [31:0] na;
    logic last;
    s_nxt = s_r;
    busy = (s_r.st != arm_pkg::DEV_IDLE);
    na = next_addr(s_r.chs, {4'h0, s_r.dh[3:0], s_r.ch, s_r.cl, s_r.sec}, max_cyl, max_head, max_sec);
    last = (s_r.wcnt == 8'(SECTOR_WORDS - 1));
    s_nxt.ack = tf.tf_rd;
    s_nxt.maddr = {s_r.dh[3:0], s_r.ch, s_r.cl, s_r.sec};
    if (tf.tf_rd) begin
      case (tf.tf_addr)
        `ARM_TF_DATA: s_nxt.rdata = f_valid ? f_data : 16'h0;
        `ARM_TF_ERR: s_nxt.rdata = {8'h0, s_r.err};
        `ARM_TF_CNT: s_nxt.rdata = {8'h0, s_r.hob ? s_r.p_cnt : s_r.cnt};
        `ARM_TF_SEC: s_nxt.rdata = {8'h0, s_r.hob ? s_r.p_sec : s_r.sec};
        `ARM_TF_CYL_LO: s_nxt.rdata = {8'h0, s_r.hob ? s_r.p_cl : s_r.cl};
        `ARM_TF_CYL_HI: s_nxt.rdata = {8'h0, s_r.hob ? s_r.p_ch : s_r.ch};
        `ARM_TF_DEV_HEAD: s_nxt.rdata = {8'h0, s_r.dh};
        // While a command runs: busy while the buffer is empty, data-request while a word waits.
        `ARM_TF_CMD: s_nxt.rdata = {8'h0, busy && !f_valid, `ARM_ST_IDLE >> 4 == 8'h5,
                                    1'b0, 1'b1, busy && f_valid, 2'b00, s_r.errb};
        `ARM_TF_DEV_CTL: s_nxt.rdata = {8'h0, s_r.hob, 7'h0};
        default: s_nxt.rdata = 16'h0;
      endcase
    end
    if (tf.tf_wr && tf.tf_addr == `ARM_TF_DEV_CTL) begin
      s_nxt.hob = tf.tf_wdata[`ARM_BIT_HOB];
    end
    if (tf.tf_wr && !busy) begin
      case (tf.tf_addr)
        `ARM_TF_CNT: begin s_nxt.p_cnt = s_r.cnt; s_nxt.cnt = tf.tf_wdata; end
        `ARM_TF_SEC: begin s_nxt.p_sec = s_r.sec; s_nxt.sec = tf.tf_wdata; end
        `ARM_TF_CYL_LO: begin s_nxt.p_cl = s_r.cl; s_nxt.cl = tf.tf_wdata; end
        `ARM_TF_CYL_HI: begin s_nxt.p_ch = s_r.ch; s_nxt.ch = tf.tf_wdata; end
        `ARM_TF_DEV_HEAD: s_nxt.dh = tf.tf_wdata;
        `ARM_TF_CMD: begin
          s_nxt.err = 8'h0;
          s_nxt.errb = 1'b0;
          if (tf.tf_wdata == `ARM_OP_NATIVE_MAX) begin
            if (s_r.dh[`ARM_BIT_LBA]) begin
              {s_nxt.dh[3:0], s_nxt.ch, s_nxt.cl, s_nxt.sec} = nm28;
            end else begin
              {s_nxt.ch, s_nxt.cl} = max_cyl;
              s_nxt.dh[3:0] = max_head;
              s_nxt.sec = max_sec;
            end
          end else if (tf.tf_wdata == `ARM_OP_NATIVE_MAX_EXT) begin
            {s_nxt.ch, s_nxt.cl, s_nxt.sec} = native_max[23:0];
            {s_nxt.p_ch, s_nxt.p_cl, s_nxt.p_sec} = native_max[47:24];
          end else if (tf.tf_wdata[7:1] == `ARM_OP_READ_SECTORS >> 1) begin
            s_nxt.st = arm_pkg::DEV_FETCH;
            s_nxt.left = (s_r.cnt == 8'h0) ? 9'h100 : {1'b0, s_r.cnt};
            s_nxt.wcnt = 8'h0;
            s_nxt.req = 1'b1;
            s_nxt.chs = !s_r.dh[`ARM_BIT_LBA];
          end else begin
            s_nxt.err[`ARM_ER_ABT] = 1'b1;
            s_nxt.errb = 1'b1;
          end
        end
        default: ;
      endcase
    end
    case (s_r.st)
      arm_pkg::DEV_IDLE: ;
      arm_pkg::DEV_FETCH: begin
        if (media_err) begin
          // The failing sector is not counted; its address stays in the task file.
          s_nxt.err[`ARM_ER_UNC] = 1'b1;
          s_nxt.errb = 1'b1;
          s_nxt.req = 1'b0;
          s_nxt.st = arm_pkg::DEV_DRAIN;
        end else if (media_valid && media_ready) begin
          s_nxt.wcnt = last ? 8'h0 : s_r.wcnt + 8'h1;
          if (last) begin
            s_nxt.left = s_r.left - 9'h1;
            if (s_r.left == 9'h1) begin
              s_nxt.req = 1'b0;
              s_nxt.st = arm_pkg::DEV_DRAIN;
            end else begin
              {s_nxt.dh[3:0], s_nxt.ch, s_nxt.cl, s_nxt.sec} = na[27:0];
            end
          end
        end
      end
      arm_pkg::DEV_DRAIN: begin
        if (!f_valid) begin
          s_nxt.st = arm_pkg::DEV_IDLE;
        end
      end
      default: s_nxt.st = arm_pkg::DEV_IDLE;
    endcase
    if (s_r.st != arm_pkg::DEV_IDLE) begin
      s_nxt.cnt = s_nxt.left[7:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0;
      s_r.st <= arm_pkg::DEV_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign tf.tf_rdata = s_r.rdata;
  assign tf.tf_ack = s_r.ack;
  assign media_req = s_r.req;
  assign media_chs = s_r.chs;
  assign media_addr = s_r.maddr;
endmodule : arm_device

/* File: core/arm_host.sv */
// Controller end: AXI4-Lite registers that drive task-file command sequences.
`timescale 1ns/100ps
`include "arm_defs.svh"

module arm_host (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic s_axi_awvalid,
  input wire logic [7:0] s_axi_awaddr,
  output logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_wready,
  output logic s_axi_bvalid,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic s_axi_arvalid,
  input wire logic [7:0] s_axi_araddr,
  output logic s_axi_arready,
  output logic s_axi_rvalid,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  input wire logic s_axi_rready,
  // Task-file link
  arm_if.host tf
);
  localparam logic [4:0] STEP_POLL = 5'd7;
  localparam logic [4:0] STEP_DATA = 5'd8;
  localparam logic [4:0] STEP_LAST = 5'd18;

  typedef struct packed {
    arm_pkg::arm_host_state_t st;
    logic [4:0] step;
    logic [7:0] op;
    logic lba;
    logic [27:0] addr;
    logic [7:0] count;
    logic busy, done;
    logic [18:0][7:0] cap;
    logic [15:0] hold;
    logic hold_v;
    logic wr, rd;
    logic [3:0] la;
    logic [7:0] lw;
    logic awr, wr_rdy, bv, arr, rv;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
  } arm_host_st_t;

  arm_host_st_t s_r, s_nxt;

  // The fixed access sequence of one command: load, poll, data, then both result copies.
  function automatic arm_pkg::arm_op_t step_op(input logic [4:0] step, input arm_host_st_t s);
    arm_pkg::arm_op_t o;
    o = '{wr: 1'b0, addr: `ARM_TF_CMD, data: 8'h0};
    case (step)
      5'd0: o = '{1'b1, `ARM_TF_DEV_CTL, 8'h00};
      5'd1: o = '{1'b1, `ARM_TF_CNT, s.count};
      5'd2: o = '{1'b1, `ARM_TF_SEC, s.addr[7:0]};
      5'd3: o = '{1'b1, `ARM_TF_CYL_LO, s.addr[15:8]};
      5'd4: o = '{1'b1, `ARM_TF_CYL_HI, s.addr[23:16]};
      5'd5: o = '{1'b1, `ARM_TF_DEV_HEAD, `ARM_DEV_HEAD_BASE | {1'b0, s.lba, 2'b0, s.addr[27:24]}};
      5'd6: o = '{1'b1, `ARM_TF_CMD, s.op};
      5'd8: o = '{1'b0, `ARM_TF_DATA, 8'h0};
      5'd9: o = '{1'b0, `ARM_TF_ERR, 8'h0};
      5'd10: o = '{1'b0, `ARM_TF_CNT, 8'h0};
      5'd11, 5'd16: o = '{1'b0, `ARM_TF_SEC, 8'h0};
      5'd12, 5'd17: o = '{1'b0, `ARM_TF_CYL_LO, 8'h0};
      5'd13, 5'd18: o = '{1'b0, `ARM_TF_CYL_HI, 8'h0};
      5'd14: o = '{1'b0, `ARM_TF_DEV_HEAD, 8'h0};
      5'd15: o = '{1'b1, `ARM_TF_DEV_CTL, 8'h80};
      default: o = '{1'b0, `ARM_TF_CMD, 8'h0};
    endcase
    return o;
  endfunction : step_op

  always_comb begin
    arm_pkg::arm_op_t o;
    logic [7:0] st8;
    s_nxt = s_r;
    o = step_op(s_r.step, s_r);
    st8 = tf.tf_rdata[7:0];
    s_nxt.wr = 1'b0;
    s_nxt.rd = 1'b0;
    // ----------------------------------------
    // Link sequencer
    // ----------------------------------------
    case (s_r.st)
      arm_pkg::HOST_IDLE: ;
      arm_pkg::HOST_ISSUE: begin
        s_nxt.wr = o.wr;
        s_nxt.rd = !o.wr;
        s_nxt.la = o.addr;
        s_nxt.lw = o.data;
        if (o.wr) begin
          s_nxt.step = s_r.step + 5'd1;
        end else begin
          s_nxt.st = arm_pkg::HOST_WAIT;
        end
      end
      arm_pkg::HOST_WAIT: begin
        if (tf.tf_ack) begin
          s_nxt.cap[s_r.step] = st8;
          s_nxt.st = arm_pkg::HOST_ISSUE;
          if (s_r.step == STEP_POLL) begin
            if (!st8[`ARM_ST_BSY]) begin
              s_nxt.step = st8[`ARM_ST_DRQ] ? STEP_DATA : STEP_DATA + 5'd1;
            end
          end else if (s_r.step == STEP_DATA) begin
            s_nxt.hold = tf.tf_rdata;
            s_nxt.hold_v = 1'b1;
            s_nxt.st = arm_pkg::HOST_HOLD;
          end else if (s_r.step == STEP_LAST) begin
            s_nxt.st = arm_pkg::HOST_IDLE;
            s_nxt.busy = 1'b0;
            s_nxt.done = 1'b1;
          end else begin
            s_nxt.step = s_r.step + 5'd1;
          end
        end
      end
      arm_pkg::HOST_HOLD: begin
        if (!s_r.hold_v) begin
          s_nxt.step = STEP_POLL;
          s_nxt.st = arm_pkg::HOST_ISSUE;
        end
      end
      default: s_nxt.st = arm_pkg::HOST_IDLE;
    endcase
    // ----------------------------------------
    // AXI4-Lite slave
    // ----------------------------------------
    s_nxt.awr = s_axi_awvalid && s_axi_wvalid && !s_r.awr && !s_r.bv;
    s_nxt.wr_rdy = s_nxt.awr;
    if (s_r.bv && s_axi_bready) begin
      s_nxt.bv = 1'b0;
    end
    if (s_r.awr) begin
      s_nxt.bv = 1'b1;
      s_nxt.bresp = `ARM_RESP_OKAY;
      case (s_axi_awaddr)
        `ARM_AX_CTRL: begin
          if (!s_r.busy && s_axi_wstrb[0]) begin
            s_nxt.op = s_axi_wdata[7:0];
            s_nxt.lba = s_axi_wdata[8];
            s_nxt.busy = 1'b1;
            s_nxt.done = 1'b0;
            s_nxt.step = 5'd0;
            s_nxt.st = arm_pkg::HOST_ISSUE;
          end
        end
        `ARM_AX_ADDR: s_nxt.addr = s_axi_wdata[27:0];
        `ARM_AX_COUNT: s_nxt.count = s_axi_wdata[7:0];
        default: s_nxt.bresp = `ARM_RESP_SLVERR;
      endcase
    end
    s_nxt.arr = s_axi_arvalid && !s_r.arr && !s_r.rv;
    if (s_r.rv && s_axi_rready) begin
      s_nxt.rv = 1'b0;
    end
    if (s_r.arr) begin
      s_nxt.rv = 1'b1;
      s_nxt.rresp = `ARM_RESP_OKAY;
      case (s_axi_araddr)
        `ARM_AX_CTRL: s_nxt.rdata = {23'h0, s_r.lba, s_r.op};
        `ARM_AX_ADDR: s_nxt.rdata = {4'h0, s_r.addr};
        `ARM_AX_COUNT: s_nxt.rdata = {24'h0, s_r.count};
        `ARM_AX_STATUS: s_nxt.rdata = {7'h0, s_r.hold_v, s_r.cap[STEP_POLL], s_r.cap[9], 5'h0,
                                       s_r.cap[STEP_POLL][`ARM_ST_ERR], s_r.done, s_r.busy};
        `ARM_AX_RES_LO: s_nxt.rdata = {s_r.cap[14], s_r.cap[13], s_r.cap[12], s_r.cap[11]};
        `ARM_AX_RES_HI: s_nxt.rdata = {s_r.cap[10], s_r.cap[18], s_r.cap[17], s_r.cap[16]};
        `ARM_AX_DATA: begin
          s_nxt.rdata = {15'h0, s_r.hold_v, s_r.hold};
          // A word captured in this same cycle survives only a read that found no word held; a read that consumed the previous one clears the flag.
          s_nxt.hold_v = s_nxt.hold_v && !s_r.hold_v;
        end
        default: begin
          s_nxt.rdata = 32'h0;
          s_nxt.rresp = `ARM_RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0;
      s_r.st <= arm_pkg::HOST_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign s_axi_awready = s_r.awr;
  assign s_axi_wready = s_r.wr_rdy;
  assign s_axi_bvalid = s_r.bv;
  assign s_axi_bresp = s_r.bresp;
  assign s_axi_arready = s_r.arr;
  assign s_axi_rvalid = s_r.rv;
  assign s_axi_rdata = s_r.rdata;
  assign s_axi_rresp = s_r.rresp;
  assign tf.tf_wr = s_r.wr;
  assign tf.tf_rd = s_r.rd;
  assign tf.tf_addr = s_r.la;
  assign tf.tf_wdata = s_r.lw;
endmodule : arm_host

/* File: bench/arm_link_sva.sv */
// Timing and status checks on the task-file link between the controller and the drive logic.
`timescale 1ns/100ps
`include "arm_defs.svh"
module arm_link_sva (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Link
  input wire logic tf_wr,
  input wire logic tf_rd,
  input wire logic [3:0] tf_addr,
  input wire logic [7:0] tf_wdata,
  input wire logic [15:0] tf_rdata,
  input wire logic tf_ack
);
  // ----
  // Last command and last read address
  // ----
  logic [7:0] cmd_r;
  logic [3:0] ra_r;
  logic seen_r;
  logic bad;
  logic mx;
  logic st;
  logic er;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmd_r <= 8'h00;
      seen_r <= 1'b0;
      ra_r <= 4'h0;
    end else begin
      if (tf_wr && tf_addr == `ARM_TF_CMD) begin
        cmd_r <= tf_wdata;
        seen_r <= 1'b1;
      end
      if (tf_rd) begin
        ra_r <= tf_addr;
      end
    end
  end
  assign mx = seen_r && (cmd_r == `ARM_OP_NATIVE_MAX || cmd_r == `ARM_OP_NATIVE_MAX_EXT);
  assign bad = seen_r && !mx && cmd_r[7:1] != 7'h10;
  assign st = tf_ack && ra_r == `ARM_TF_CMD;
  assign er = tf_ack && ra_r == `ARM_TF_ERR;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_ack; tf_rd |=> tf_ack; endproperty
  a_ack: assert property (p_ack) else $error("read not answered");
  property p_cause; tf_ack |-> $past(tf_rd); endproperty
  a_cause: assert property (p_cause) else $error("answer without read");
  property p_stand; !tf_ack |-> $stable(tf_rdata); endproperty
  a_stand: assert property (p_stand) else $error("read data moved");
  property p_bsydrq; st |-> !(tf_rdata[`ARM_ST_BSY] && tf_rdata[`ARM_ST_DRQ]); endproperty
  a_bsydrq: assert property (p_bsydrq) else $error("busy with data request");
  property p_fixed; st |-> tf_rdata[6] && tf_rdata[4]; endproperty
  a_fixed: assert property (p_fixed) else $error("ready or seek bit low");
  property p_abst; st && bad |-> tf_rdata[`ARM_ST_ERR] && !tf_rdata[`ARM_ST_BSY]; endproperty
  a_abst: assert property (p_abst) else $error("refused command status");
  property p_aber; er && seen_r |-> tf_rdata[`ARM_ER_ABT] == bad; endproperty
  a_aber: assert property (p_aber) else $error("aborted flag wrong");
  property p_mx; st && mx |-> !tf_rdata[`ARM_ST_ERR] && !tf_rdata[`ARM_ST_BSY]; endproperty
  a_mx: assert property (p_mx) else $error("native max status");
endmodule : arm_link_sva

/* File: bench/ata_read_max_and_sector_cmds_tb.sv */
// Bench joining controller and drive logic, driven over AXI4-Lite and the media stream.
`timescale 1ns/100ps
`include "arm_defs.svh"
module ata_read_max_and_sector_cmds_tb;
  localparam int SW = 2;
  localparam logic [33:0] M24 = 34'h3_00ff_ffff;
  localparam logic [33:0] M28 = 34'h3_0fff_ffff;
  typedef struct packed {
    logic [33:0] m;
    logic [33:0] v;
  } arm_note_t;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, media_req, media_ready;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic media_chs;
  logic [27:0] media_addr;
  logic [31:0] s_axi_rdata;
  logic [31:0] rng = 32'h95f1;
  logic [47:0] native_max = 48'h0;
  logic [15:0] max_cyl = 16'h0;
  logic [3:0] max_head = 4'h0;
  logic [7:0] max_sec = 8'h0;
  logic media_valid = 1'b0, media_err = 1'b0;
  logic [15:0] media_data = 16'h0;
  int num_errors = 0, tests_run = 0, mcnt = 0, err_at = -1;
  bit err_done = 1'b0;
  arm_note_t rq[$];
  logic [1:0] bq[$];
  arm_if tf_if ();
  arm_host arm_host_i (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awaddr, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wready, .s_axi_bvalid, .s_axi_bresp, .s_axi_bready, .s_axi_arvalid,
    .s_axi_araddr, .s_axi_arready, .s_axi_rvalid, .s_axi_rdata, .s_axi_rresp, .s_axi_rready, .tf(tf_if.host));
  arm_device #(.SECTOR_WORDS(SW), .FIFO_DEPTH(8)) arm_device_i (.aclk, .aresetn, .tf(tf_if.device), .native_max,
    .max_cyl, .max_head, .max_sec, .media_req, .media_chs, .media_addr, .media_valid, .media_data,
    .media_ready, .media_err);
  arm_link_sva arm_link_sva_i (.aclk, .aresetn, .tf_wr(tf_if.tf_wr), .tf_rd(tf_if.tf_rd), .tf_addr(tf_if.tf_addr),
    .tf_wdata(tf_if.tf_wdata), .tf_rdata(tf_if.tf_rdata), .tf_ack(tf_if.tf_ack));
  initial begin
    forever #5 aclk = ~aclk;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  function automatic logic [15:0] pat(input int k);
    return 16'h3c00 ^ k[15:0];
  endfunction : pat
  task automatic chk(input logic [33:0] seen, input logic [33:0] exp, input logic [33:0] m);
    tests_run++;
    if ((seen & m) !== (exp & m)) begin
      num_errors++;
      $display("BAD %0t: got %h want %h", $time, seen & m, exp & m);
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish
  // ----
  // Bus cycles
  // ----
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    bit aw_ok;
    bit w_ok;
    bq.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready === 1'b1) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (s_axi_bvalid !== 1'b1) @(posedge aclk);
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, input logic [33:0] m, input logic [33:0] v, output logic [31:0] d);
    rq.push_back('{m, v});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge aclk);
    d = s_axi_rdata;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask : axi_rd
  task automatic poll(input int b, input logic v);
    logic [31:0] d;
    do axi_rd(`ARM_AX_STATUS, 34'h0, 34'h0, d); while (d[b] !== v);
  endtask : poll
  task automatic run_cmd(input logic [7:0] op, input logic lba, input logic [27:0] a, input logic [7:0] n);
    axi_wr(`ARM_AX_ADDR, {4'h0, a}, `ARM_RESP_OKAY);
    axi_wr(`ARM_AX_COUNT, {24'h0, n}, `ARM_RESP_OKAY);
    axi_wr(`ARM_AX_CTRL, {23'h0, lba, op}, `ARM_RESP_OKAY);
  endtask : run_cmd
  task automatic get_words(input int n);
    logic [31:0] d;
    for (int j = 0; j < n; j++) begin
      poll(24, 1'b1);
      axi_rd(`ARM_AX_DATA, 34'h3_0001_ffff, {18'h1, pat(j)}, d);
    end
  endtask : get_words
  always @(posedge aclk) begin
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
      if (rq[0].m !== 34'h0) chk({s_axi_rresp, s_axi_rdata}, rq[0].v, rq[0].m);
      void'(rq.pop_front());
    end
    if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1) begin
      chk({32'h0, s_axi_bresp}, {32'h0, bq[0]}, 34'h3);
      void'(bq.pop_front());
    end
  end
  // Media source stalls at random and withholds the word at err_at, so the failing sector is cut short.
  always @(posedge aclk) begin
    if (media_valid && media_ready && media_req) mcnt = mcnt + 1;
    if (media_req !== 1'b1) begin
      mcnt = 0;
      err_done = 1'b0;
    end
    rng = xs(rng);
    if (!media_valid || media_ready || !media_req) begin
      media_valid <= (media_req === 1'b1) && (mcnt != err_at) && (rng[1:0] != 2'b00);
      media_data <= pat(mcnt);
    end
    media_err <= (media_req === 1'b1) && (mcnt == err_at) && !err_done;
    if (media_req === 1'b1 && mcnt == err_at) err_done = 1'b1;
  end
  initial begin
    repeat (60000) @(posedge aclk);
    num_errors++;
    $display("BAD %0t: timeout", $time);
    tally_and_finish();
  end
  initial begin
    logic [31:0] d;
    logic [31:0] g;
    logic [47:0] nm;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int i = 0; i < 2; i++) begin
      nm = (i == 0) ? 48'h0001_2345_6789 : 48'h0000_0abc_def1;
      native_max <= nm;
      run_cmd(`ARM_OP_NATIVE_MAX, 1'b1, 28'h0, 8'h0);
      poll(0, 1'b0);
      axi_rd(`ARM_AX_RES_LO, M28, {6'h0, (nm > 48'h0fff_ffff) ? `ARM_SAT_28 : nm[27:0]}, d);
      run_cmd(`ARM_OP_NATIVE_MAX_EXT, 1'b1, 28'h0, 8'h0);
      poll(0, 1'b0);
      axi_rd(`ARM_AX_RES_LO, M24, {10'h0, nm[23:0]}, d);
      axi_rd(`ARM_AX_RES_HI, M24, {10'h0, nm[47:24]}, d);
    end
    $display("native max test done");
    g = rng;
    max_cyl <= g[15:0];
    max_head <= g[19:16];
    // The top sector stays above the CHS start sector of the read test, so no track wrap occurs there.
    max_sec <= g[27:20] | 8'h80;
    run_cmd(`ARM_OP_NATIVE_MAX, 1'b0, 28'h0, 8'h0);
    poll(0, 1'b0);
    axi_rd(`ARM_AX_RES_LO, M28, {6'h0, g[19:16], g[15:0], g[27:20] | 8'h80}, d);
    run_cmd(8'h91, 1'b1, 28'h0, 8'h0);
    poll(0, 1'b0);
    axi_rd(`ARM_AX_STATUS, 34'h3_0001_0405, 34'h0_0001_0404, d);
    axi_wr(8'h40, 32'h0, `ARM_RESP_SLVERR);
    axi_rd(8'h40, 34'h3_ffff_ffff, {`ARM_RESP_SLVERR, 32'h0}, d);
    $display("geometry and refusal test done");
    for (int i = 0; i < 2; i++) begin
      err_at = (i == 0) ? -1 : SW + 1;
      run_cmd(8'h20 | i[7:0], i == 0, 28'h123_4567, 8'h3);
      get_words((i == 0) ? 3 * SW : SW + 1);
      poll(0, 1'b0);
      axi_rd(`ARM_AX_RES_LO, M28, {6'h0, 28'h123_4567 + 28'(2 - i)}, d);
      chk({5'h0, media_chs, media_addr}, {5'h0, i[0], 28'h123_4567 + 28'(2 - i)}, 34'h1fff_ffff);
      axi_rd(`ARM_AX_RES_HI, 34'h3_ff00_0000, {2'b00, (i == 0) ? 8'h0 : 8'h2, 24'h0}, d);
      axi_rd(`ARM_AX_STATUS, 34'h3_0000_4005, (i == 0) ? 34'h0 : 34'h4004, d);
      axi_rd(`ARM_AX_DATA, 34'h3_0001_0000, 34'h0, d);
    end
    $display("sector read test done");
    err_at = -1;
    run_cmd(`ARM_OP_READ_SECTORS, 1'b1, 28'h0, 8'h0);
    repeat (80) @(posedge aclk);
    chk({32'h0, media_req, media_ready}, 34'h2, 34'h3);
    get_words(256 * SW);
    poll(0, 1'b0);
    axi_rd(`ARM_AX_RES_LO, M28, 34'h0ff, d);
    $display("full count test done");
    tally_and_finish();
  end
endmodule : ata_read_max_and_sector_cmds_tb
